// file: shared/psi_cfg.svh
// register offsets, field positions and reset values for the status/irq bank
`ifndef PSI_CFG_SVH
`define PSI_CFG_SVH
// ==========================================================
// register offsets
`define PSI_ADDR_BASIC_STATUS 5'h01
`define PSI_ADDR_SUMMARY 5'h10
`define PSI_ADDR_CONTROL 5'h11
`define PSI_ADDR_EVENT 5'h12
`define PSI_ADDR_IRQ_MASK 5'h1E
// ==========================================================
// summary status fields
`define PSI_SUM_REMOTE 6
`define PSI_SUM_JABBER 5
`define PSI_SUM_ANEG 4
`define PSI_SUM_LOOP 3
`define PSI_SUM_DUPLEX 2
`define PSI_SUM_SPEED 1
`define PSI_SUM_LINK 0
// ==========================================================
// control fields
`define PSI_CTL_TEST 2
`define PSI_CTL_GATE 1
`define PSI_CTL_OE 0
`define PSI_CTL_RESET 3'h0
// ==========================================================
// event status fields, enables sit eight bits lower
`define PSI_EV_LQ 15
`define PSI_EV_ED 14
`define PSI_EV_LINK 13
`define PSI_EV_SPD 12
`define PSI_EV_DUP 11
`define PSI_EV_ANC 10
`define PSI_EV_FHF 9
`define PSI_EV_RHF 8
`define PSI_EN_RESET 8'h00
`define PSI_MASK_RESET 8'hFF
`endif

// file: shared/psi_pkg.sv
// types shared by the status/irq bank
package psi_pkg;
  typedef logic [4:0] psi_addr_t;
  typedef logic [15:0] psi_data_t;
  typedef logic [7:0] psi_ev_t;
endpackage : psi_pkg

// file: hdl/psi_status_irq.sv
// summary status register, interrupt control and event status bank
`timescale 1ns/1ps
`default_nettype none
`include "psi_cfg.svh"
// ==========================================================
// How it works
// R1: remote fault latches high; cleared by basic status read or reset.
// R2: jabber bit mirrors input; summary read leaves it alone.
// R3: bit 4 shows autoneg complete, bit 3 shows loopback.
// R4: bit 2 shows resolved duplex, one meaning full duplex.
// R5: bit 1 shows resolved speed, one meaning 10 Mb/s.
// R6: software trusts speed and duplex only with valid link.
// R7: bit 0 mirrors link status; summary read leaves it alone.
// R8: control at 11h; bits 15:3 ignore writes, read zero.
// R9: test bit keeps the interrupt asserted while set.
// R10: gate bit passes or suppresses event based interrupts at the shared pin only.
// R11: oe bit makes shared pin an interrupt output or powerdown input.
// R12: sources are link quality, energy, link, speed, duplex, autoneg, counters half.
// R13: summary at 10h, bits 6:0 reset zero and read only.
// R14: reading event status at 12h clears pending events.
// R15: events latch regardless of enables; pin needs enable and gate, system irq needs mask bit clear.
// R16: pin asserts while enabled event pending or test bit set; code also needs the gate bit for the event case.
module psi_status_irq
  import psi_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire psi_pkg::psi_addr_t reg_addr,
  input wire psi_pkg::psi_data_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output psi_pkg::psi_data_t reg_rdata,
  // status inputs from the phy core
  input wire logic remote_fault_evt,
  input wire logic jabber_stat,
  input wire logic aneg_done,
  input wire logic loopback_on,
  input wire logic full_duplex,
  input wire logic speed_10,
  input wire logic link_up,
  // event pulses from the phy core
  input wire logic link_quality_evt,
  input wire logic energy_evt,
  input wire logic fc_half_evt,
  input wire logic rxerr_half_evt,
  // shared powerdown or interrupt pin
  input wire logic powerdown_or_irq_pin_in,
  output logic powerdown_or_irq_pin_out,
  output logic powerdown_or_irq_pin_oe,
  output logic powerdown_req,
  // system interrupt
  output logic irq
);
  import psi_pkg::*;

  logic remote_fault;
  logic [2:0] ctrl;
  psi_ev_t ev_pend;
  psi_ev_t ev_en;
  psi_ev_t irq_mask;
  psi_ev_t ev_hit;
  logic link_q, spd_q, dup_q, aneg_q;
  logic rd_basic, rd_event, irq_raw;
  psi_data_t next_rdata;

  assign rd_basic = reg_rd && reg_addr == `PSI_ADDR_BASIC_STATUS;
  assign rd_event = reg_rd && reg_addr == `PSI_ADDR_EVENT;

  // ==========================================================
  // remote fault latch; a new fault beats the clearing read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      remote_fault <= 1'b0;
    end else if (remote_fault_evt) begin
      remote_fault <= 1'b1; // R1
    end else if (rd_basic) begin
      remote_fault <= 1'b0; // R1
    end
  end

  // ==========================================================
  // control register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= `PSI_CTL_RESET;
    end else if (reg_wr && reg_addr == `PSI_ADDR_CONTROL) begin
      ctrl <= reg_wdata[2:0]; // R8
    end
  end

  // ==========================================================
  // event enables (low byte of 12h) and system irq mask
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ev_en <= `PSI_EN_RESET;
      irq_mask <= `PSI_MASK_RESET;
    end else if (reg_wr) begin
      if (reg_addr == `PSI_ADDR_EVENT) begin
        ev_en <= reg_wdata[7:0];
      end
      if (reg_addr == `PSI_ADDR_IRQ_MASK) begin
        irq_mask <= reg_wdata[7:0];
      end
    end
  end

  // ==========================================================
  // change detection on resolved state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_q <= 1'b0;
      spd_q <= 1'b0;
      dup_q <= 1'b0;
      aneg_q <= 1'b0;
    end else begin
      link_q <= link_up;
      spd_q <= speed_10;
      dup_q <= full_duplex;
      aneg_q <= aneg_done;
    end
  end

  always_comb begin
    ev_hit = 8'h00;
    ev_hit[`PSI_EV_LQ - 8] = link_quality_evt;
    ev_hit[`PSI_EV_ED - 8] = energy_evt; // R12
    ev_hit[`PSI_EV_LINK - 8] = link_up ^ link_q; // R12
    ev_hit[`PSI_EV_SPD - 8] = speed_10 ^ spd_q; // R12
    ev_hit[`PSI_EV_DUP - 8] = full_duplex ^ dup_q; // R12
    ev_hit[`PSI_EV_ANC - 8] = aneg_done & ~aneg_q; // R12
    ev_hit[`PSI_EV_FHF - 8] = fc_half_evt; // R12
    ev_hit[`PSI_EV_RHF - 8] = rxerr_half_evt; // R12
  end

  // ==========================================================
  // pending events, clear on read; a same-cycle event survives the read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ev_pend <= 8'h00;
    end else begin
      ev_pend <= (rd_event ? 8'h00 : ev_pend) | ev_hit; // R14 R15
    end
  end

  // ==========================================================
  // interrupt generation
  assign irq_raw = ctrl[`PSI_CTL_TEST] // R9
    | (ctrl[`PSI_CTL_GATE] & |(ev_pend & ev_en)); // R10 R15 R16

  // pin drives only in output mode; powerdown honoured only as input
  assign powerdown_or_irq_pin_oe = ctrl[`PSI_CTL_OE]; // R11
  assign powerdown_or_irq_pin_out = irq_raw; // R16
  assign powerdown_req = ~ctrl[`PSI_CTL_OE] & powerdown_or_irq_pin_in; // R11
  // system irq: any pending event, masked, plus test force
  assign irq = ctrl[`PSI_CTL_TEST] | |(ev_pend & ~irq_mask);

  // ==========================================================
  // read mux, data one cycle after the strobe
  always_comb begin
    next_rdata = 16'h0000;
    case (reg_addr)
      `PSI_ADDR_SUMMARY: begin
        next_rdata[`PSI_SUM_REMOTE] = remote_fault; // R13
        next_rdata[`PSI_SUM_JABBER] = jabber_stat; // R2
        next_rdata[`PSI_SUM_ANEG] = aneg_done; // R3
        next_rdata[`PSI_SUM_LOOP] = loopback_on; // R3
        next_rdata[`PSI_SUM_DUPLEX] = full_duplex; // R4
        next_rdata[`PSI_SUM_SPEED] = speed_10; // R5
        next_rdata[`PSI_SUM_LINK] = link_up; // R7
        next_rdata[7] = irq_raw;
      end
      `PSI_ADDR_CONTROL: next_rdata = {13'h0, ctrl}; // R8
      `PSI_ADDR_EVENT: next_rdata = {ev_pend, ev_en};
      `PSI_ADDR_IRQ_MASK: next_rdata = {8'h00, irq_mask};
      default: next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ==========================================================
  // checks
  // remote fault latch
  chk_remote_clear: assert property ( // R1
    @(posedge clk) disable iff (sys_rst)
    rd_basic && !remote_fault_evt |=> !remote_fault)
    else $error("remote fault not cleared by basic status read");
  chk_remote_set: assert property ( // R1
    @(posedge clk) disable iff (sys_rst)
    remote_fault_evt |=> remote_fault)
    else $error("remote fault not latched");
  chk_remote_hold: assert property ( // R1
    @(posedge clk) disable iff (sys_rst)
    remote_fault && !rd_basic |=> remote_fault)
    else $error("remote fault dropped without a basic status read");
  // summary readback and write protection
  chk_summary_link: assert property ( // R7
    @(posedge clk) disable iff (sys_rst)
    reg_rd && reg_addr == `PSI_ADDR_SUMMARY
    |=> reg_rdata[0] == $past(link_up)
        && reg_rdata[5] == $past(jabber_stat))
    else $error("summary link or jabber bit wrong");
  chk_summary_speed: assert property ( // R4
    @(posedge clk) disable iff (sys_rst)
    reg_rd && reg_addr == `PSI_ADDR_SUMMARY
    |=> reg_rdata[2:1] == {$past(full_duplex), $past(speed_10)})
    else $error("summary duplex or speed bit wrong");
  chk_summary_aneg: assert property ( // R3
    @(posedge clk) disable iff (sys_rst)
    reg_rd && reg_addr == `PSI_ADDR_SUMMARY
    |=> reg_rdata[4:3] == {$past(aneg_done), $past(loopback_on)})
    else $error("summary autoneg or loopback bit wrong");
  chk_summary_fault: assert property ( // R13
    @(posedge clk) disable iff (sys_rst)
    reg_rd && reg_addr == `PSI_ADDR_SUMMARY
    |=> reg_rdata[6] == $past(remote_fault)
        && reg_rdata[15:8] == 8'h00)
    else $error("summary fault or upper bits wrong");
  chk_summary_ro: assert property ( // R13
    @(posedge clk) disable iff (sys_rst)
    reg_wr && reg_addr == `PSI_ADDR_SUMMARY && !remote_fault_evt
    |=> remote_fault == $past(remote_fault))
    else $error("summary write changed the fault latch");
  // control and read port
  chk_ctrl_reserved: assert property ( // R8
    @(posedge clk) disable iff (sys_rst)
    reg_rd && reg_addr == `PSI_ADDR_CONTROL |=> reg_rdata[15:3] == 13'h0)
    else $error("control reserved bits not zero");
  chk_ctrl_write: assert property ( // R8
    @(posedge clk) disable iff (sys_rst)
    reg_wr && reg_addr == `PSI_ADDR_CONTROL
    |=> ctrl == $past(reg_wdata[2:0]))
    else $error("control write did not land");
  chk_ctrl_keep: assert property ( // R8
    @(posedge clk) disable iff (sys_rst)
    !(reg_wr && reg_addr == `PSI_ADDR_CONTROL) |=> $stable(ctrl))
    else $error("control changed without a write to it");
  chk_rdata_idle: assert property (
    @(posedge clk) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data left standing after its cycle");
  // interrupt and shared pin
  chk_test_irq: assert property ( // R9
    @(posedge clk) disable iff (sys_rst)
    ctrl[`PSI_CTL_TEST] |-> powerdown_or_irq_pin_out && irq)
    else $error("test bit did not force interrupt");
  chk_gate_off: assert property ( // R10
    @(posedge clk) disable iff (sys_rst)
    !ctrl[`PSI_CTL_GATE] && !ctrl[`PSI_CTL_TEST]
    |-> !powerdown_or_irq_pin_out)
    else $error("event interrupt passed while gated off");
  chk_gate_on: assert property ( // R10
    @(posedge clk) disable iff (sys_rst)
    ctrl[`PSI_CTL_GATE] && |(ev_pend & ev_en) |-> powerdown_or_irq_pin_out)
    else $error("enabled pending event did not interrupt");
  chk_pin_dir: assert property ( // R11
    @(posedge clk) disable iff (sys_rst)
    powerdown_or_irq_pin_oe == ctrl[`PSI_CTL_OE]
    && !(ctrl[`PSI_CTL_OE] && powerdown_req))
    else $error("shared pin direction wrong");
  chk_powerdown_in: assert property ( // R11
    @(posedge clk) disable iff (sys_rst)
    !ctrl[`PSI_CTL_OE] |-> powerdown_req == powerdown_or_irq_pin_in)
    else $error("powerdown input not passed through");
  chk_pin_release: assert property ( // R16
    @(posedge clk) disable iff (sys_rst)
    rd_event && ev_hit == 8'h00 && !ctrl[`PSI_CTL_TEST]
    |=> !powerdown_or_irq_pin_out)
    else $error("shared pin still asserted after event read");
  chk_mask_all: assert property (
    @(posedge clk) disable iff (sys_rst)
    &irq_mask && !ctrl[`PSI_CTL_TEST] |-> !irq)
    else $error("system interrupt raised while fully masked");
  // event status
  chk_event_clear: assert property ( // R14
    @(posedge clk) disable iff (sys_rst)
    rd_event && ev_hit == 8'h00 |=> ev_pend == 8'h00)
    else $error("event status not cleared by read");
  chk_event_rdata: assert property ( // R14
    @(posedge clk) disable iff (sys_rst)
    rd_event |=> reg_rdata == {$past(ev_pend), $past(ev_en)})
    else $error("event status read data wrong");
  chk_event_hold: assert property ( // R15
    @(posedge clk) disable iff (sys_rst)
    !rd_event |=> (ev_pend & $past(ev_pend)) == $past(ev_pend))
    else $error("pending event lost without a read");
  chk_event_latch: assert property ( // R15
    @(posedge clk) disable iff (sys_rst)
    link_up != link_q |=> ev_pend[`PSI_EV_LINK - 8])
    else $error("link change not latched");
  chk_speed_latch: assert property ( // R12
    @(posedge clk) disable iff (sys_rst)
    speed_10 != spd_q |=> ev_pend[`PSI_EV_SPD - 8])
    else $error("speed change not latched");
  chk_aneg_latch: assert property ( // R12
    @(posedge clk) disable iff (sys_rst)
    aneg_done && !aneg_q |=> ev_pend[`PSI_EV_ANC - 8])
    else $error("autoneg completion not latched");
endmodule : psi_status_irq
`default_nettype wire

// file: test/psi_phy_model.sv
// phy core stand-in: status levels and event pulses
`timescale 1ns/1ps
`default_nettype none
module psi_phy_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // requested levels {jabber, aneg, loop, duplex, speed, link}
  input wire logic [5:0] lv_set,
  // requested strobes {remote, quality, energy, fc half, rx half}
  input wire logic [4:0] ev_set,
  // levels and strobes as the core shows them
  output logic [5:0] lv,
  output logic [4:0] ev
);
  // ==========================================================
  // drive
  // registered: core outputs only ever move just after an edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lv <= 6'h00;
      ev <= 5'h00;
    end else begin
      lv <= lv_set;
      ev <= ev_set;
    end
  end
endmodule : psi_phy_model
`default_nettype wire

// file: test/phy_status_irq_control_test.sv
// self-checking bench for the status/irq bank
`timescale 1ns/1ps
`default_nettype none
`include "psi_cfg.svh"
module phy_status_irq_control_test;
  import psi_pkg::*;
  logic clk, sys_rst, reg_wr, reg_rd, pin_in, rd_d;
  psi_addr_t reg_addr;
  psi_data_t reg_wdata, reg_rdata;
  logic pin_out, pin_oe, pd_req, irq;
  logic [5:0] lv, v, lv_set;
  logic [4:0] ev, ev_set;
  logic [31:0] exp_q[$];
  logic [31:0] note;
  logic [15:0] msk;
  int mismatches, checks, n;
  psi_phy_model phy (
    .clk(clk), .rst(sys_rst), .lv_set(lv_set), .ev_set(ev_set),
    .lv(lv), .ev(ev));
  psi_status_irq dut (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .remote_fault_evt(ev[4]),
    .jabber_stat(lv[5]), .aneg_done(lv[4]), .loopback_on(lv[3]),
    .full_duplex(lv[2]), .speed_10(lv[1]), .link_up(lv[0]),
    .link_quality_evt(ev[3]), .energy_evt(ev[2]),
    .fc_half_evt(ev[1]), .rxerr_half_evt(ev[0]),
    .powerdown_or_irq_pin_in(pin_in),
    .powerdown_or_irq_pin_out(pin_out),
    .powerdown_or_irq_pin_oe(pin_oe), .powerdown_req(pd_req),
    .irq(irq));
  // ==========================================================
  // tasks
  task automatic cmp_word(input psi_data_t g, input psi_data_t e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp_word
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick
  // core levels reach the block one edge after the request
  task automatic set_lv(input logic [5:0] l);
    lv_set <= l;
    tick(1);
  endtask : set_lv
  // one cycle high, as the core's event strobes are
  task automatic pulse(input int i);
    ev_set <= 5'h01 << i;
    tick(1);
    ev_set <= 5'h00;
    tick(1);
  endtask : pulse
  // extra edge after the strobe keeps back-to-back calls clean
  task automatic wr(input psi_addr_t a, input psi_data_t d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick(1);
    reg_wr <= 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input psi_addr_t a, input psi_data_t e,
                    input psi_data_t m);
    exp_q.push_back({m, e});
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick(1);
    reg_rd <= 1'b0;
    tick(1);
  endtask : rd
  // {oe, out, irq, powerdown}, sampled mid-cycle
  task automatic chk_pins(input logic [3:0] e);
    @(negedge clk);
    cmp_word({12'h000, pin_oe, pin_out, irq, pd_req}, {12'h000, e});
    tick(1);
  endtask : chk_pins
  always @(posedge clk) begin
    if (rd_d && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      cmp_word(reg_rdata & note[31:16], note[15:0] & note[31:16]);
    end
    rd_d <= reg_rd;
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
  // ==========================================================
  // sequence
  initial begin
    {sys_rst, reg_wr, reg_rd, pin_in} = 4'h8;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    lv_set = 6'h00;
    ev_set = 5'h00;
    n = $urandom(63133);
    tick(8);
    sys_rst <= 1'b0;
    pin_in <= 1'b1;
    tick(1);
    rd(`PSI_ADDR_SUMMARY, 16'h0000, 16'hFFFF);
    rd(`PSI_ADDR_CONTROL, 16'h0000, 16'hFFFF);
    rd(`PSI_ADDR_IRQ_MASK, 16'h00FF, 16'hFFFF);
    wr(5'h05, 16'hFFFF);
    rd(5'h05, 16'h0000, 16'hFFFF);
    wr(`PSI_ADDR_SUMMARY, 16'hFFFF);
    for (n = 0; n < 8; n++) begin
      v = 6'($urandom);
      set_lv(v);
      tick(2);
      // speed and duplex trusted only with link
      msk = v[0] ? 16'h007F : 16'h0079;
      rd(`PSI_ADDR_SUMMARY, {10'h000, v}, msk);
      rd(`PSI_ADDR_SUMMARY, {10'h000, v}, msk);
    end
    set_lv(6'h00);
    pulse(4);
    tick(2);
    rd(`PSI_ADDR_SUMMARY, 16'h0040, 16'h0040);
    rd(`PSI_ADDR_SUMMARY, 16'h0040, 16'h0040);
    rd(`PSI_ADDR_BASIC_STATUS, 16'h0000, 16'hFFFF);
    rd(`PSI_ADDR_SUMMARY, 16'h0000, 16'h0040);
    wr(`PSI_ADDR_CONTROL, 16'hFFFF);
    rd(`PSI_ADDR_CONTROL, 16'h0007, 16'hFFFF);
    chk_pins(4'b1110);
    wr(`PSI_ADDR_CONTROL, 16'h0000);
    chk_pins(4'b0001);
    pin_in <= 1'b0;
    chk_pins(4'b0000);
    pin_in <= 1'b1;
    rd(`PSI_ADDR_EVENT, 16'h0000, 16'h00FF);
    wr(`PSI_ADDR_EVENT, 16'h00FF);
    wr(`PSI_ADDR_IRQ_MASK, 16'h0000);
    wr(`PSI_ADDR_CONTROL, 16'h0003);
    for (n = 15; n >= 8; n--) begin
      case (n)
        15: pulse(3);
        14: pulse(2);
        13: set_lv(6'h01);
        12: set_lv(6'h03);
        11: set_lv(6'h07);
        10: set_lv(6'h17);
        9: pulse(1);
        default: pulse(0);
      endcase
      tick(2);
      chk_pins(4'b1110);
      rd(`PSI_ADDR_EVENT, 16'h00FF | (16'h1 << n), 16'hFFFF);
      chk_pins(4'b1000);
    end
    wr(`PSI_ADDR_CONTROL, 16'h0001);
    pulse(2);
    tick(2);
    chk_pins(4'b1010);
    rd(`PSI_ADDR_EVENT, 16'h40FF, 16'hFFFF);
    wr(`PSI_ADDR_EVENT, 16'h0000);
    wr(`PSI_ADDR_CONTROL, 16'h0003);
    wr(`PSI_ADDR_IRQ_MASK, 16'h00FF);
    pulse(0);
    tick(2);
    chk_pins(4'b1000);
    rd(`PSI_ADDR_EVENT, 16'h0100, 16'hFFFF);
    // second reset mid-run drops the fault latch and the control bits
    pulse(4);
    tick(2);
    sys_rst <= 1'b1;
    tick(3);
    sys_rst <= 1'b0;
    tick(1);
    rd(`PSI_ADDR_SUMMARY, 16'h0000, 16'h0040);
    rd(`PSI_ADDR_CONTROL, 16'h0000, 16'hFFFF);
    rd(`PSI_ADDR_IRQ_MASK, 16'h00FF, 16'hFFFF);
    chk_pins(4'b0001);
    tick(2);
    print_verdict();
  end
endmodule : phy_status_irq_control_test
`default_nettype wire
